// File: design/pbs_pkg.sv
// Constants, state codes and instruction codes for the periphery boundary-scan port
package pbs_pkg;
	localparam int IR_W = 3;
	localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
	localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
	localparam logic [IR_W-1:0] IR_SAMPLE = 3'h2;
	localparam logic [IR_W-1:0] IR_CLAMP = 3'h3;
	localparam logic [IR_W-1:0] IR_HIGHZ = 3'h4;
	localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
	// Fixed pattern loaded into the instruction shift stage in Capture-IR
	localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
	localparam int ID_W = 32;
	localparam int CELLS_PER_PIN = 3;
	localparam int CELL_IN = 0;
	localparam int CELL_OUT = 1;
	localparam int CELL_OE = 2;
	localparam int DEF_PINS = 8;
	// Arbitrary identification value; bit 0 must stay set
	localparam logic [ID_W-1:0] DEF_ID_CODE = 32'h1000_0001;

	typedef enum logic [3:0] {
		PBS_TLR = 4'h0,
		PBS_RTI = 4'h1,
		PBS_SEL_DR = 4'h2,
		PBS_CAP_DR = 4'h3,
		PBS_SH_DR = 4'h4,
		PBS_EX1_DR = 4'h5,
		PBS_PAU_DR = 4'h6,
		PBS_EX2_DR = 4'h7,
		PBS_UPD_DR = 4'h8,
		PBS_SEL_IR = 4'h9,
		PBS_CAP_IR = 4'hA,
		PBS_SH_IR = 4'hB,
		PBS_EX1_IR = 4'hC,
		PBS_PAU_IR = 4'hD,
		PBS_EX2_IR = 4'hE,
		PBS_UPD_IR = 4'hF
	} pbs_state_e;
endpackage : pbs_pkg

// File: design/pbs_bsr_if.sv
// Control and data between the scan controller and the boundary register chain
`timescale 1ns/1ps
interface pbs_bsr_if #(parameter int BW = 24);
	logic capture;
	logic shift;
	logic update;
	logic sdi;
	logic sdo;
	logic [BW-1:0] upd_q;
	modport ctrl (output capture, output shift, output update, output sdi, input sdo, input upd_q);
	modport chain (input capture, input shift, input update, input sdi, output sdo, output upd_q);
endinterface : pbs_bsr_if

// File: design/pbs_bsr.sv
// Boundary-scan register: capture/shift chain plus update latch, three cells per pin
`timescale 1ns/1ps
module pbs_bsr #(
	parameter int PINS = pbs_pkg::DEF_PINS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic [PINS-1:0] pad_in,
	input wire logic [PINS-1:0] sys_out,
	input wire logic [PINS-1:0] sys_oe_n,
	pbs_bsr_if.chain bus
);
	import pbs_pkg::*;
	localparam int BW = PINS * CELLS_PER_PIN;
	logic [PINS-1:0] pad_s1;
	logic [PINS-1:0] pad_s2;
	logic [BW-1:0] chain;
	logic [BW-1:0] cap_val;
	logic [BW-1:0] upd;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pad_s1 <= '0;
			pad_s2 <= '0;
		end
		else if (ce)
		begin
			pad_s1 <= pad_in;
			pad_s2 <= pad_s1;
		end
	end

	for (genvar i = 0; i < PINS; i++)
	begin : g_cell
		assign cap_val[i*CELLS_PER_PIN+CELL_IN] = pad_s2[i];
		assign cap_val[i*CELLS_PER_PIN+CELL_OUT] = sys_out[i];
		assign cap_val[i*CELLS_PER_PIN+CELL_OE] = sys_oe_n[i];
	end

	// Capture samples pins without disturbing them; shift moves toward bit 0
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			chain <= '0;
		else if (ce && bus.capture)
			chain <= cap_val; // see [R4]
		else if (ce && bus.shift)
			chain <= {bus.sdi, chain[BW-1:1]}; // see [R4]
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			upd <= '0;
		else if (ce && bus.update)
			upd <= chain; // see [R6]
	end

	assign bus.sdo = chain[0];
	assign bus.upd_q = upd;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_update_latch: assert property (ce && bus.update |=> upd == $past(chain)) // see [R6]
		else $error("update latch did not take the chain");
	a_shift_chain: assert property (ce && bus.shift && !bus.capture |=> chain[BW-1] == $past(bus.sdi)) // see [R4]
		else $error("chain did not shift in serial data");
	c_update: cover property (ce && bus.update);
endmodule : pbs_bsr

// File: design/pbs_tap.sv
// Periphery boundary-scan TAP: controller, instruction register, bypass, id and pin control
`timescale 1ns/1ps
// Summary of operation
// [R1] Scan logic is independent of the multiplexer and overrides it on conflict.
// [R2] Own TAP controller, separate from configuration TAP, with 3-bit instruction register.
// [R3] Uses only its five pins; tester drives four, device drives data out.
// [R4] Supports SAMPLE/PRELOAD, BYPASS and EXTEST with standard behaviour.
// [R5] Supports HIGHZ, CLAMP and IDCODE with standard behaviour.
// [R6] Holds instruction, bypass, boundary and identification registers plus controller.
// [R7] State advances on test clock rising edge according to mode select.
// [R8] After reset controller sits in Test-Logic-Reset with IDCODE current.
// [R9] Instruction shift stage moves to current instruction on falling edge in Update-IR.
// [R10] Codes: EXTEST 000, IDCODE 001, SAMPLE 010, CLAMP 011, HIGHZ 100, BYPASS 111.
// [R11] Test reset low forces Test-Logic-Reset and IDCODE without clock edges.
module pbs_tap #(
	parameter int PINS = pbs_pkg::DEF_PINS,
	parameter logic [pbs_pkg::ID_W-1:0] ID_CODE = pbs_pkg::DEF_ID_CODE
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic periphery_scan_reset_n,
	input wire logic periphery_scan_mode_sel,
	input wire logic periphery_scan_clock,
	input wire logic periphery_scan_data_in,
	output logic periphery_scan_data_out,
	output logic periphery_scan_data_out_oe_n,
	input wire logic [PINS-1:0] sys_out,
	input wire logic [PINS-1:0] sys_oe_n,
	output logic [PINS-1:0] sys_in,
	input wire logic [PINS-1:0] pad_in,
	output logic [PINS-1:0] pad_out,
	output logic [PINS-1:0] pad_oe_n,
	output logic scan_owns_pins
);
	import pbs_pkg::*;
	localparam int BW = PINS * CELLS_PER_PIN;

	logic trst_s1, trst_s2, tms_s1, tms_s2, tdi_s1, tdi_s2, tck_s1, tck_s2, tck_s3;
	logic tck_rise, tck_fall, run;
	pbs_state_e st;
	logic [IR_W-1:0] ir;
	logic [IR_W-1:0] ir_sh;
	logic byp;
	logic [ID_W-1:0] id_sh;
	logic sel_bsr, sel_id, pins_test, pins_float, dr_bit;
	pbs_bsr_if #(.BW(BW)) bsr_bus ();

	// Two-stage synchronisers on all tester pins; clock edges found after the second stage
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			{trst_s1, trst_s2} <= 2'h0;
			{tms_s1, tms_s2} <= 2'h3;
			{tdi_s1, tdi_s2} <= 2'h3;
			{tck_s1, tck_s2, tck_s3} <= 3'h0;
		end
		else if (ce)
		begin
			trst_s1 <= periphery_scan_reset_n; // see [R3]
			trst_s2 <= trst_s1;
			tms_s1 <= periphery_scan_mode_sel;
			tms_s2 <= tms_s1;
			tdi_s1 <= periphery_scan_data_in;
			tdi_s2 <= tdi_s1;
			tck_s1 <= periphery_scan_clock;
			tck_s2 <= tck_s1;
			tck_s3 <= tck_s2;
		end
	end

	assign tck_rise = tck_s2 && !tck_s3;
	assign tck_fall = !tck_s2 && tck_s3;
	assign run = ce && trst_s2;

	function automatic pbs_state_e next_state(input pbs_state_e s, input logic m);
		unique case (s)
			PBS_TLR: next_state = m ? PBS_TLR : PBS_RTI;
			PBS_RTI: next_state = m ? PBS_SEL_DR : PBS_RTI;
			PBS_SEL_DR: next_state = m ? PBS_SEL_IR : PBS_CAP_DR;
			PBS_CAP_DR: next_state = m ? PBS_EX1_DR : PBS_SH_DR;
			PBS_SH_DR: next_state = m ? PBS_EX1_DR : PBS_SH_DR;
			PBS_EX1_DR: next_state = m ? PBS_UPD_DR : PBS_PAU_DR;
			PBS_PAU_DR: next_state = m ? PBS_EX2_DR : PBS_PAU_DR;
			PBS_EX2_DR: next_state = m ? PBS_UPD_DR : PBS_SH_DR;
			PBS_UPD_DR: next_state = m ? PBS_SEL_DR : PBS_RTI;
			PBS_SEL_IR: next_state = m ? PBS_TLR : PBS_CAP_IR;
			PBS_CAP_IR: next_state = m ? PBS_EX1_IR : PBS_SH_IR;
			PBS_SH_IR: next_state = m ? PBS_EX1_IR : PBS_SH_IR;
			PBS_EX1_IR: next_state = m ? PBS_UPD_IR : PBS_PAU_IR;
			PBS_PAU_IR: next_state = m ? PBS_EX2_IR : PBS_PAU_IR;
			PBS_EX2_IR: next_state = m ? PBS_UPD_IR : PBS_SH_IR;
			PBS_UPD_IR: next_state = m ? PBS_SEL_DR : PBS_RTI;
		endcase
	endfunction : next_state

	// Controller state, forced home by system reset or test reset
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			st <= PBS_TLR; // see [R8]
		else if (ce && !trst_s2)
			st <= PBS_TLR; // see [R11]
		else if (run && tck_rise)
			st <= next_state(st, tms_s2); // see [R2] see [R7]
	end

	// Instruction shift stage
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ir_sh <= IR_CAPTURE;
		else if (run && tck_rise && st == PBS_CAP_IR)
			ir_sh <= IR_CAPTURE; // see [R6]
		else if (run && tck_rise && st == PBS_SH_IR)
			ir_sh <= {tdi_s2, ir_sh[IR_W-1:1]}; // see [R2]
	end

	// Current instruction, updated on the falling test-clock edge in Update-IR
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ir <= IR_IDCODE; // see [R8]
		else if (ce && (!trst_s2 || st == PBS_TLR))
			ir <= IR_IDCODE; // see [R11]
		else if (run && tck_fall && st == PBS_UPD_IR)
			ir <= ir_sh; // see [R9]
	end

	// Instruction decode; unassigned codes select the bypass bit
	assign sel_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLE); // see [R10]
	assign sel_id = (ir == IR_IDCODE); // see [R10]
	assign pins_test = (ir == IR_EXTEST) || (ir == IR_CLAMP); // see [R4] see [R5]
	assign pins_float = (ir == IR_HIGHZ); // see [R5]

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			byp <= 1'b0;
		else if (run && tck_rise && st == PBS_CAP_DR)
			byp <= 1'b0;
		else if (run && tck_rise && st == PBS_SH_DR)
			byp <= tdi_s2; // see [R4]
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			id_sh <= ID_CODE;
		else if (run && tck_rise && st == PBS_CAP_DR && sel_id)
			id_sh <= ID_CODE; // see [R5]
		else if (run && tck_rise && st == PBS_SH_DR && sel_id)
			id_sh <= {tdi_s2, id_sh[ID_W-1:1]}; // see [R5]
	end

	assign bsr_bus.capture = run && tck_rise && st == PBS_CAP_DR && sel_bsr;
	assign bsr_bus.shift = run && tck_rise && st == PBS_SH_DR && sel_bsr;
	assign bsr_bus.update = run && tck_fall && st == PBS_UPD_DR && sel_bsr;
	assign bsr_bus.sdi = tdi_s2;

	pbs_bsr #(.PINS(PINS)) u_bsr (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.pad_in(pad_in),
		.sys_out(sys_out),
		.sys_oe_n(sys_oe_n),
		.bus(bsr_bus)
	);

	assign dr_bit = sel_bsr ? bsr_bus.sdo : (sel_id ? id_sh[0] : byp);

	// Serial output changes on the falling test-clock edge and floats outside shift states
	always_ff @(posedge clk_sys)
	begin
		if (rst || (ce && !trst_s2))
		begin
			periphery_scan_data_out <= 1'b0;
			periphery_scan_data_out_oe_n <= 1'b1;
		end
		else if (run && tck_fall)
		begin
			periphery_scan_data_out <= (st == PBS_SH_IR) ? ir_sh[0] : dr_bit; // see [R3]
			periphery_scan_data_out_oe_n <= !(st == PBS_SH_IR || st == PBS_SH_DR); // see [R3]
		end
	end

	// Pin control: test instructions take the pins from the multiplexer side
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pad_out <= '0;
			pad_oe_n <= '1;
			sys_in <= '0;
			scan_owns_pins <= 1'b0;
		end
		else if (ce)
		begin
			scan_owns_pins <= pins_test || pins_float; // see [R1]
			for (int i = 0; i < PINS; i++)
			begin
				sys_in[i] <= pad_in[i];
				if (pins_float)
				begin
					pad_out[i] <= 1'b0;
					pad_oe_n[i] <= 1'b1; // see [R5]
				end
				else if (pins_test)
				begin
					pad_out[i] <= bsr_bus.upd_q[i*CELLS_PER_PIN+CELL_OUT]; // see [R1] see [R4]
					pad_oe_n[i] <= bsr_bus.upd_q[i*CELLS_PER_PIN+CELL_OE];
				end
				else
				begin
					pad_out[i] <= sys_out[i];
					pad_oe_n[i] <= sys_oe_n[i];
				end
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_trst_forces_home: assert property (ce && !trst_s2 |=> st == PBS_TLR && ir == IR_IDCODE) // see [R11]
		else $error("test reset did not force home state");
	a_ir_update_fall: assert property (run && tck_fall && st == PBS_UPD_IR |=> ir == $past(ir_sh)) // see [R9]
		else $error("instruction not latched in Update-IR");
	a_state_holds_idle: assert property (run && !tck_rise |=> st == $past(st)) // see [R7]
		else $error("state moved without a test clock rise");
	a_tlr_stays_high: assert property (run && tck_rise && st == PBS_TLR && tms_s2 |=> st == PBS_TLR) // see [R7]
		else $error("left Test-Logic-Reset with mode select high");
	a_ir_capture_value: assert property (run && tck_rise && st == PBS_CAP_IR |=> ir_sh == IR_CAPTURE) // see [R6]
		else $error("capture-IR pattern wrong");
	a_idcode_capture: assert property (run && tck_rise && st == PBS_CAP_DR && sel_id |=> id_sh == ID_CODE) // see [R5]
		else $error("identification value not captured");
	a_bypass_shift: assert property (run && tck_rise && st == PBS_SH_DR |=> byp == $past(tdi_s2)) // see [R4]
		else $error("bypass bit did not follow data in");
	a_highz_float: assert property (ce && ir == IR_HIGHZ ##1 ir == IR_HIGHZ |-> pad_oe_n == '1) // see [R5]
		else $error("pins driven under HIGHZ");
	a_extest_drive: assert property (ce && ir == IR_EXTEST |=> pad_out[0] == $past(bsr_bus.upd_q[CELL_OUT])) // see [R4]
		else $error("EXTEST pin not from update latch");
	a_normal_pass: assert property (ce && ir == IR_BYPASS |=> pad_out == $past(sys_out) && !scan_owns_pins) // see [R1]
		else $error("normal pins disturbed by BYPASS");
	a_tdo_float: assert property (run && tck_fall && st == PBS_RTI |=> periphery_scan_data_out_oe_n) // see [R3]
		else $error("data out driven outside shift");
	a_ir_idcode_tlr: assert property (ce && st == PBS_TLR |=> ir == IR_IDCODE) // see [R8]
		else $error("IDCODE not current in Test-Logic-Reset");

	c_shift_ir: cover property (run && tck_rise && st == PBS_SH_IR);
	c_extest: cover property (ir == IR_EXTEST && st == PBS_UPD_DR);
	c_highz: cover property (ir == IR_HIGHZ);
	c_idcode_shift: cover property (sel_id && st == PBS_SH_DR && tck_rise);
endmodule : pbs_tap

// File: sim/pbs_tester.sv
// Boundary-scan tester model driving the four scan inputs
`timescale 1ns/1ps
module pbs_tester (
	input wire logic clk_sys,
	output logic srst_n,
	output logic sm,
	output logic sc,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe_n
);
	int oe_bad = 0;
	logic oe_seen;

	// Scan clock idles low between frames
	initial
	begin
		srst_n = 1'b1;
		sm = 1'b1;
		sc = 1'b0;
		sdi = 1'b0;
	end

	// One scan clock period: mode and data set up 4 cycles before the rise
	task tick(input logic m, input logic d, output logic q);
		sm <= m;
		sdi <= d;
		repeat (4) @(posedge clk_sys);
		// A released data line reads as the inverse of its last value
		q = sdo_oe_n ? !sdo : sdo;
		oe_seen = sdo_oe_n;
		sc <= 1'b1;
		repeat (8) @(posedge clk_sys);
		sc <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : tick

	// From Run-Test-Idle through one IR or DR scan back to Run-Test-Idle, LSB first
	task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, 1'b0, q);
		if (ir)
			tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int k = 0; k < n; k++)
		begin
			tick(k == n - 1, din[k], q);
			dout[k] = q;
			if (oe_seen !== 1'b0)
				oe_bad++;
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask : scan

	// Test reset pulse with the scan clock stopped, then step to Run-Test-Idle
	task trst;
		logic q;
		srst_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		srst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		tick(1'b0, 1'b0, q);
	endtask : trst
endmodule : pbs_tester

// File: sim/pbs_tap_bench.sv
// Self-checking bench for the periphery boundary-scan port
`timescale 1ns/1ps
module pbs_tap_bench;
	import pbs_pkg::*;
	// Arbitrary identification value with bit 0 set
	localparam logic [ID_W-1:0] ID = 32'h2000_0003;
	// Row: {scan owns pins, instruction code}
	localparam logic [3:0] ROWS [8] = '{4'h8, 4'h1, 4'h2, 4'hB, 4'hC, 4'h7, 4'h5, 4'h6};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] sys_out = 8'h96;
	logic [7:0] sys_oe_n = 8'h0F;
	logic [7:0] pad_in = 8'h3C;
	logic [7:0] sys_in, pad_out, pad_oe_n, e_out, e_oe, got;
	logic sm, sc, sdi, sdo, sdo_oe_n, srst_n, owns, q;
	logic [31:0] d;
	logic [23:0] pat = 24'hC3_5A_69;
	int n_errors = 0;
	int n_tests = 0;

	always #5 clk_sys = ~clk_sys;

	pbs_tap #(.PINS(8), .ID_CODE(ID)) pbs_tap_i (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.periphery_scan_reset_n(srst_n),
		.periphery_scan_mode_sel(sm),
		.periphery_scan_clock(sc),
		.periphery_scan_data_in(sdi),
		.periphery_scan_data_out(sdo),
		.periphery_scan_data_out_oe_n(sdo_oe_n),
		.sys_out(sys_out),
		.sys_oe_n(sys_oe_n),
		.sys_in(sys_in),
		.pad_in(pad_in),
		.pad_out(pad_out),
		.pad_oe_n(pad_oe_n),
		.scan_owns_pins(owns)
	);

	pbs_tester pbs_tester_i (
		.clk_sys(clk_sys),
		.srst_n(srst_n),
		.sm(sm),
		.sc(sc),
		.sdi(sdi),
		.sdo(sdo),
		.sdo_oe_n(sdo_oe_n)
	);

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task results;
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	initial
	begin
		repeat (100000) @(posedge clk_sys);
		n_errors++;
		results;
	end

	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (8) @(posedge clk_sys);
		check("oe_n", sdo_oe_n, 32'h1);
		check("owns", owns, 32'h0);
		check("pad_out", pad_out, sys_out);
		check("pad_oe_n", pad_oe_n, sys_oe_n);
		check("sys_in", sys_in, pad_in);
		// Mode select high keeps the controller in Test-Logic-Reset
		pbs_tester_i.tick(1'b1, 1'b0, q);
		pbs_tester_i.tick(1'b0, 1'b0, q);
		pbs_tester_i.scan(1'b0, 32, 32'h0, d);
		check("idcode", d, ID);
		pbs_tester_i.scan(1'b1, 3, {29'h0, IR_BYPASS}, d);
		check("ir_capture", d, 32'h1);
		pbs_tester_i.scan(1'b0, 8, 32'hA5, d);
		check("bypass", d, 32'h4A);
		for (int r = 0; r < 8; r++)
		begin
			pbs_tester_i.scan(1'b1, 3, {29'h0, ROWS[r][2:0]}, d);
			repeat (4) @(posedge clk_sys);
			check("owns", owns, ROWS[r][3]);
			if (ROWS[r][2:0] == IR_HIGHZ)
				check("highz", pad_oe_n, 8'hFF);
			if (!ROWS[r][3])
				check("pass", pad_out, sys_out);
		end
		// Preload under SAMPLE, then drive the pins from it under EXTEST
		pbs_tester_i.scan(1'b1, 3, {29'h0, IR_SAMPLE}, d);
		pbs_tester_i.scan(1'b0, 24, {8'h0, pat}, d);
		for (int i = 0; i < 8; i++)
		begin
			got[i] = d[3*i];
			e_out[i] = pat[3*i+1];
			e_oe[i] = pat[3*i+2];
		end
		check("sample", got, pad_in);
		check("pass", pad_out, sys_out);
		pbs_tester_i.scan(1'b1, 3, {29'h0, IR_EXTEST}, d);
		sys_out <= 8'h69;
		repeat (4) @(posedge clk_sys);
		check("ext_out", pad_out, e_out);
		check("ext_oe", pad_oe_n, e_oe);
		// Under EXTEST the pads are captured and a new pattern is driven after Update-DR
		pbs_tester_i.scan(1'b0, 24, {8'h0, ~pat}, d);
		for (int i = 0; i < 8; i++)
		begin
			got[i] = d[3*i];
			e_out[i] = !pat[3*i+1];
			e_oe[i] = !pat[3*i+2];
		end
		check("ext_cap", got, pad_in);
		check("ext_upd", pad_out, e_out);
		check("ext_upd_oe", pad_oe_n, e_oe);
		pbs_tester_i.scan(1'b1, 3, {29'h0, IR_CLAMP}, d);
		repeat (4) @(posedge clk_sys);
		check("clamp", pad_out, e_out);
		check("clamp_oe", pad_oe_n, e_oe);
		pbs_tester_i.trst();
		check("owns", owns, 32'h0);
		check("pass", pad_out, sys_out);
		// Clock enable low: a scan clock edge and a core change must both be ignored
		ce <= 1'b0;
		sys_out <= 8'hA5;
		pbs_tester_i.tick(1'b1, 1'b0, q);
		check("frozen", pad_out, 8'h69);
		ce <= 1'b1;
		pbs_tester_i.scan(1'b0, 32, 32'h0, d);
		check("idcode", d, ID);
		check("pass", pad_out, sys_out);
		check("oe_bad", pbs_tester_i.oe_bad, 32'h0);
		results;
	end
endmodule : pbs_tap_bench
